// file: dv/rbc_board_model.sv
`timescale 1ns/1ps

// Board strap pins and processor core stand-in
module rbc_board_model
  import rbc_pkg::*;
(
  input  wire logic              clk,       // System clock
  input  wire logic              sampling,  // Pins read as straps
  input  wire logic              core_run,  // Core out of reset
  input  wire logic              strap_en,  // Bench asks for straps
  input  wire logic [5:0]        straps,    // Pin config, boot select
  input  wire logic [3:0]        fetch_dly, // Cycles before first fetch
  output logic      [ADDR_W-1:0] pins,      // Address pins
  output logic                   fetch      // First fetch strobe
);
  logic [4:0] cnt;
  logic       done;

  // Defined pin levels before the first edge
  initial begin
    pins  = 14'h0000;
    fetch = 1'b0;
  end

  // Straps held on the pins, else busy address traffic that never settles
  always @(negedge clk) begin
    if (strap_en || sampling) begin
      pins <= {straps[1:0], straps[5:2], 8'hA5};
    end else begin
      pins <= ~pins;
    end
  end

  // Core fetches once, promptly or slowly, after its reset lifts
  always @(negedge clk) begin
    if (!core_run) begin
      cnt   <= 5'h00;
      done  <= 1'b0;
      fetch <= 1'b0;
    end else if (!done && cnt == {1'b0, fetch_dly}) begin
      fetch <= 1'b1;
      done  <= 1'b1;
    end else begin
      fetch <= 1'b0;
      cnt   <= cnt + 5'h01;
    end
  end
endmodule : rbc_board_model

// file: dv/reset_default_boot_config_tb.sv
`timescale 1ns/1ps

// Self-checking bench for the reset default configuration block
module reset_default_boot_config_tb;
  import rbc_pkg::*;
  localparam int SLEN = 3;
  logic        clk, rst_n, ce, warm, maxr, fetch, pll_we, tim_we, core_n, ovr, samp, strap_en;
  logic [1:0]  pll_wb, pll_wn, pll_byp, pll_en;
  logic [3:0]  tim_s, a_s, apc, fdly, cfg;
  logic [5:0]  tim_t, a_t, bcfg, straps;
  logic [2:0]  tim_h, a_h;
  logic [13:0] pins;
  logic [40:0] pwr, mod_en;
  logic [31:0] jump;
  logic [1:0]  sel;
  int          miscompares, num_checks, n;

  rbc_top #(.SAMPLE_LEN(SLEN)) DUT (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .WARM_RST_REQ(warm), .MAX_RST_REQ(maxr),
    .ASYNC_ADDR_BUS_IN(pins), .FIRST_FETCH(fetch), .PLL_WR_EN(pll_we),
    .PLL_WR_BYPASS(pll_wb), .PLL_WR_ENABLE(pll_wn), .TIMING_WR_EN(tim_we),
    .TIMING_WR_SETUP(tim_s), .TIMING_WR_STROBE(tim_t), .TIMING_WR_HOLD(tim_h),
    .PLL_BYPASS(pll_byp), .PLL_ENABLE(pll_en), .POWER_DOMAIN_ON(pwr),
    .MODULE_ENABLE(mod_en), .CORE_RESET_N(core_n), .FETCH_OVERRIDE(ovr),
    .JUMP_TARGET(jump), .BOOT_CONFIG_REG(bcfg), .ASYNC_PIN_CONFIG(apc),
    .STRAP_SAMPLING(samp), .ASYNC_SETUP(a_s), .ASYNC_STROBE(a_t), .ASYNC_HOLD(a_h));

  rbc_board_model u_board (
    .clk(clk), .sampling(samp), .core_run(core_n), .strap_en(strap_en),
    .straps(straps), .fetch_dly(fdly), .pins(pins), .fetch(fetch));

  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  // Expected module enables for a boot select
  function automatic logic [40:0] exp_en(input logic [1:0] s);
    logic [40:0] e;
    e        = 41'h000_0000_0000;
    e[38:29] = 10'h3FF;
    e[27]    = 1'b1;
    e[3:2]   = {2{s != 2'h2}};
    e[14]    = (s != 2'h2);
    e[15]    = (s == 2'h2);
    e[19]    = (s == 2'h3);
    e[22]    = (s != 2'h1);
    return e;
  endfunction : exp_en

  // One reset of the given kind with writes held that must be refused
  task automatic do_reset(input int kind);
    @(negedge clk);
    strap_en = 1'b1;
    straps   = {cfg, sel};
    if (kind == 0) rst_n = 1'b0;
    else if (kind == 1) warm = 1'b1;
    else maxr = 1'b1;
    @(negedge clk);
    warm = 1'b0;
    maxr = 1'b0;
    chk(core_n, 1'b0, "core held in reset");
    chk(samp, 1'b1, "pins read as straps");
    chk(mod_en, 41'h0, "modules off while sampling");
    {pll_we, pll_wb, pll_wn, tim_we, tim_s, tim_t, tim_h} = {1'b1, 4'h3, 1'b1, 13'h0};
    if (kind == 0) repeat (3) @(negedge clk);
    rst_n = 1'b1;
    for (n = 0; n < 20 && core_n !== 1'b1; n++) @(negedge clk);
    pll_we = 1'b0;
    tim_we = 1'b0;
    chk(core_n, 1'b1, "core released");
    chk(samp, 1'b0, "pins handed back");
    chk(pwr, 41'h17F_FFFE_FFFF, "power domains");
    chk(mod_en, exp_en(sel), "module states");
    chk({pll_byp, pll_en}, 4'hC, "pll defaults");
    chk(jump, (sel == 2'h1) ? 32'h0200_0000 : 32'h0000_8000, "jump target");
    chk(ovr, 1'b1, "fetch override");
    chk(bcfg, {cfg, sel}, "boot config");
    chk(apc, cfg, "pin config");
    chk({a_s, a_t, a_h}, {4'hF, 6'h3F, 3'h7}, "wait states");
    strap_en = 1'b0;
  endtask : do_reset

  task automatic give_verdict();
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  // Watchdog
  initial begin
    #50000;
    miscompares++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    give_verdict();
  end

  // Main sequence
  initial begin
    {rst_n, ce, warm, maxr, pll_we, tim_we, strap_en} = 7'b0100001;
    {pll_wb, pll_wn, tim_s, tim_t, tim_h, fdly} = '0;
    {sel, cfg} = 6'h34;
    straps = 6'h34;
    void'($urandom(93));
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      sel  = 2'(i % 4);
      cfg  = 4'($urandom);
      fdly = (i == 3) ? 4'hC : 4'($urandom % 4);
      do_reset(i % 3);
      for (n = 0; n < 20 && ovr !== 1'b0; n++) @(negedge clk);
      chk(ovr, 1'b0, "override after first fetch");
      // Back to back writes, each visible one edge later
      pll_we = 1'b1;
      tim_we = 1'b1;
      for (int k = 0; k < 5; k++) begin
        {pll_wb, pll_wn, tim_s, tim_t, tim_h} = 17'($urandom);
        @(negedge clk);
        chk({pll_byp, pll_en}, {pll_wb, pll_wn}, "pll write");
        chk({a_s, a_t, a_h}, {tim_s, tim_t, tim_h}, "timing write");
      end
      // Clock enable low freezes the timing fields
      ce = 1'b0;
      tim_s = ~tim_s;
      repeat (3) @(negedge clk);
      chk(a_s, 4'(~tim_s), "frozen while disabled");
      ce = 1'b1;
      pll_we = 1'b0;
      tim_we = 1'b0;
      // Pins busy as address lines, latched straps stay put
      repeat (8) @(negedge clk);
      chk(bcfg, {cfg, sel}, "straps held");
      chk(mod_en, exp_en(sel), "modules held");
      $display("test %0d done: reset kind %0d boot select %0d", i, i % 3, sel);
    end
    give_verdict();
  end
endmodule : reset_default_boot_config_tb

// file: verilog/rbc_pkg.sv
package rbc_pkg;

  // Module table geometry
  localparam int          MOD_COUNT      = 41;
  localparam int          PLL_COUNT      = 2;
  localparam int          ADDR_W         = 14;

  // Strap field positions on the async address bus
  localparam int          SEL_LSB        = 12;
  localparam int          SEL_W          = 2;
  localparam int          CFG_LSB        = 8;
  localparam int          CFG_W          = 4;

  // Strap defaults given by the internal pulls
  localparam logic [1:0]  SEL_PULL       = 2'h0;
  localparam logic [3:0]  CFG_PULL       = 4'hD;

  // Boot select codes
  localparam logic [1:0]  BOOT_NAND      = 2'h0;
  localparam logic [1:0]  BOOT_ASYNC     = 2'h1;
  localparam logic [1:0]  BOOT_CARD      = 2'h2;
  localparam logic [1:0]  BOOT_UART      = 2'h3;

  // First-fetch jump targets
  localparam logic [31:0] ROM_VECTOR     = 32'h0000_8000;
  localparam logic [31:0] ASYNC_VECTOR   = 32'h0200_0000;

  // Reference clock that runs the chip while the PLLs are bypassed
  localparam int          REF_CLOCK_MHZ  = 24;

  // PLL controller reset values: bypassed and disabled
  localparam logic [1:0]  PLL_BYPASS_RST = 2'h3;
  localparam logic [1:0]  PLL_ENABLE_RST = 2'h0;

  // Slowest async wait states, fields hold cycles minus one
  localparam int          SETUP_CYCLES   = 16;
  localparam int          STROBE_CYCLES  = 64;
  localparam int          HOLD_CYCLES    = 8;
  localparam logic [3:0]  SETUP_RST      = 4'(SETUP_CYCLES - 1);
  localparam logic [5:0]  STROBE_RST     = 6'(STROBE_CYCLES - 1);
  localparam logic [2:0]  HOLD_RST       = 3'(HOLD_CYCLES - 1);

  // Module numbers with strap-dependent defaults, and always-enabled timer 0
  localparam int          MOD_DMA_CC     = 2;
  localparam int          MOD_DMA_TC0    = 3;
  localparam int          MOD_ASYNC_MEM  = 14;
  localparam int          MOD_CARD0      = 15;
  localparam int          MOD_UART0      = 19;
  localparam int          MOD_SPI0       = 22;
  localparam int          MOD_TIMER0     = 27;

  // Always enabled: timer 0, timer 2, system, core, bus 32..38
  localparam logic [40:0] MOD_ALWAYS_EN  = 41'h07F_E800_0000;
  // Powered on: every module but reserved 16 and 39
  localparam logic [40:0] PWR_ON_MASK    = 41'h17F_FFFE_FFFF;

  // Strap sampling window after reset, in clock cycles
  localparam int          SAMPLE_CYCLES  = 2;

  typedef enum logic [1:0] {
    PH_SAMPLE = 2'b01,
    PH_RUN    = 2'b10
  } rbc_phase_t;

  typedef struct packed {
    rbc_phase_t  phase;
    logic [1:0]  cnt;
    logic [1:0]  boot_sel;
    logic [3:0]  pin_cfg;
    logic [1:0]  pll_bypass;
    logic [1:0]  pll_enable;
    logic [40:0] mod_en;
    logic        override;
    logic [31:0] vector;
    logic [3:0]  setup;
    logic [5:0]  strobe;
    logic [2:0]  hold;
  } rbc_state_t;

  localparam rbc_state_t STATE_RST = '{
    phase: PH_SAMPLE, cnt: 2'h0, boot_sel: SEL_PULL, pin_cfg: CFG_PULL,
    pll_bypass: PLL_BYPASS_RST, pll_enable: PLL_ENABLE_RST, mod_en: 41'h000_0000_0000,
    override: 1'b0, vector: ROM_VECTOR, setup: SETUP_RST, strobe: STROBE_RST,
    hold: HOLD_RST};

endpackage : rbc_pkg

// file: verilog/rbc_top.sv
`timescale 1ns/1ps

module rbc_top
  import rbc_pkg::*;
#(
  parameter int SAMPLE_LEN = rbc_pkg::SAMPLE_CYCLES  // Strap settle window in cycles
) (
  input  wire logic                          CLK,               // 100 MHz clock
  input  wire logic                          RST_N,             // Power-on reset, async
  input  wire logic                          CE,                // Clock enable
  input  wire logic                          WARM_RST_REQ,      // Warm reset pulse
  input  wire logic                          MAX_RST_REQ,       // Max reset pulse
  input  wire logic [rbc_pkg::ADDR_W-1:0]    ASYNC_ADDR_BUS_IN, // Address pins, straps
  input  wire logic                          FIRST_FETCH,       // Core fetch strobe
  input  wire logic                          PLL_WR_EN,         // PLL control write
  input  wire logic [rbc_pkg::PLL_COUNT-1:0] PLL_WR_BYPASS,     // New bypass bits
  input  wire logic [rbc_pkg::PLL_COUNT-1:0] PLL_WR_ENABLE,     // New enable bits
  input  wire logic                          TIMING_WR_EN,      // Wait state write
  input  wire logic [3:0]                    TIMING_WR_SETUP,   // New setup field
  input  wire logic [5:0]                    TIMING_WR_STROBE,  // New strobe field
  input  wire logic [2:0]                    TIMING_WR_HOLD,    // New hold field
  output logic [rbc_pkg::PLL_COUNT-1:0]      PLL_BYPASS,        // PLL bypass per PLL
  output logic [rbc_pkg::PLL_COUNT-1:0]      PLL_ENABLE,        // PLL enable per PLL
  output logic [rbc_pkg::MOD_COUNT-1:0]      POWER_DOMAIN_ON,   // Domain on per module
  output logic [rbc_pkg::MOD_COUNT-1:0]      MODULE_ENABLE,     // 1 enable, 0 sync reset
  output logic                               CORE_RESET_N,      // Core held while low
  output logic                               FETCH_OVERRIDE,    // Replace first fetch
  output logic [31:0]                        JUMP_TARGET,       // Forced jump address
  output logic [5:0]                         BOOT_CONFIG_REG,   // Pin config, boot select
  output logic [rbc_pkg::CFG_W-1:0]          ASYNC_PIN_CONFIG,  // Async pin setup
  output logic                               STRAP_SAMPLING,    // Pins act as straps
  output logic [3:0]                         ASYNC_SETUP,       // Setup cycles minus one
  output logic [5:0]                         ASYNC_STROBE,      // Strobe cycles minus one
  output logic [2:0]                         ASYNC_HOLD         // Hold cycles minus one
);
  import rbc_pkg::*;

  // Elaboration check on the sampling window
  if (SAMPLE_LEN < 1 || SAMPLE_LEN > 4) begin : g_bad_len
    $error("SAMPLE_LEN must lie between 1 and 4");
  end

  localparam logic [1:0] LAST_CNT = 2'(SAMPLE_LEN - 1);

  logic       rst_meta;
  logic       rst_sync;
  logic [5:0] strap_meta;
  logic [5:0] strap_sync;
  rbc_state_t r_reg;
  rbc_state_t r_next;
  logic       any_rst;
  logic [1:0] sel_pin;
  logic [3:0] cfg_pin;

  // Reset release through two flops
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else if (CE) begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Strap pins through two flops, held at pull values in power-on reset only
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_meta <= {SEL_PULL, CFG_PULL};
      strap_sync <= {SEL_PULL, CFG_PULL};
    end else if (CE) begin
      strap_meta <= ASYNC_ADDR_BUS_IN[SEL_LSB+SEL_W-1:CFG_LSB];
      strap_sync <= strap_meta;
    end
  end

  assign any_rst = WARM_RST_REQ | MAX_RST_REQ;
  assign sel_pin = strap_sync[CFG_W+SEL_W-1:CFG_W];
  assign cfg_pin = strap_sync[CFG_W-1:0];

  // Next-state logic for the whole configuration
  always_comb begin
    r_next = r_reg;
    if (any_rst) begin
      // Warm and max reset reload every default, same as power-on
      r_next = STATE_RST;
    end else begin
      unique case (r_reg.phase)
        PH_SAMPLE: begin
          r_next.cnt = r_reg.cnt + 2'h1;
          if (r_reg.cnt == LAST_CNT) begin
            // Latch straps once and hand pins back
            r_next.phase    = PH_RUN;
            r_next.cnt      = 2'h0;
            r_next.boot_sel = sel_pin;
            r_next.pin_cfg  = cfg_pin;
            r_next.override = 1'b1;
            r_next.vector   = (sel_pin == BOOT_ASYNC) ? ASYNC_VECTOR : ROM_VECTOR;
            r_next.mod_en   = MOD_ALWAYS_EN;
            r_next.mod_en[MOD_DMA_CC]    = (sel_pin != BOOT_CARD);
            r_next.mod_en[MOD_DMA_TC0]   = (sel_pin != BOOT_CARD);
            r_next.mod_en[MOD_ASYNC_MEM] = (sel_pin != BOOT_CARD);
            r_next.mod_en[MOD_CARD0]     = (sel_pin == BOOT_CARD);
            r_next.mod_en[MOD_UART0]     = (sel_pin == BOOT_UART);
            r_next.mod_en[MOD_SPI0]      = (sel_pin != BOOT_ASYNC);
          end
        end
        PH_RUN: begin
          // First fetch consumes the forced jump
          if (FIRST_FETCH) begin
            r_next.override = 1'b0;
          end
          if (PLL_WR_EN) begin
            r_next.pll_bypass = PLL_WR_BYPASS;
            r_next.pll_enable = PLL_WR_ENABLE;
          end
          // Timing stays at default until software rewrites it
          if (TIMING_WR_EN) begin
            r_next.setup  = TIMING_WR_SETUP;
            r_next.strobe = TIMING_WR_STROBE;
            r_next.hold   = TIMING_WR_HOLD;
          end
        end
      endcase
    end
  end

  // State register, frozen while CE is low or reset is held
  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      r_reg <= STATE_RST;
    end else if (CE) begin
      r_reg <= r_next;
    end
  end

  // Outputs from the state register, power domains from the fixed mask
  assign PLL_BYPASS       = r_reg.pll_bypass;
  assign PLL_ENABLE       = r_reg.pll_enable;
  assign POWER_DOMAIN_ON  = PWR_ON_MASK;
  assign MODULE_ENABLE    = r_reg.mod_en;
  assign CORE_RESET_N     = (r_reg.phase == PH_RUN);
  assign FETCH_OVERRIDE   = r_reg.override;
  assign JUMP_TARGET      = r_reg.vector;
  assign BOOT_CONFIG_REG  = {r_reg.pin_cfg, r_reg.boot_sel};
  assign ASYNC_PIN_CONFIG = r_reg.pin_cfg;
  assign STRAP_SAMPLING   = (r_reg.phase == PH_SAMPLE);
  assign ASYNC_SETUP      = r_reg.setup;
  assign ASYNC_STROBE     = r_reg.strobe;
  assign ASYNC_HOLD       = r_reg.hold;

  // Checks on the default configuration
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_sync);

  property p_reset_kind;
    (CE && any_rst) |=> (STRAP_SAMPLING && !CORE_RESET_N && PLL_BYPASS == PLL_BYPASS_RST);
  endproperty
  a_reset_kind: assert property (p_reset_kind)
    else $error("warm or max reset did not restore defaults");

  property p_pll_default;
    STRAP_SAMPLING |-> (PLL_BYPASS == PLL_BYPASS_RST && PLL_ENABLE == PLL_ENABLE_RST);
  endproperty
  a_pll_default: assert property (p_pll_default)
    else $error("PLL not bypassed and disabled after reset");

  property p_power_on;
    POWER_DOMAIN_ON[16] == 1'b0 && POWER_DOMAIN_ON[39] == 1'b0 && POWER_DOMAIN_ON[15:0] == 16'hFFFF;
  endproperty
  a_power_on: assert property (p_power_on)
    else $error("power domain state wrong");

  property p_sync_reset;
    CORE_RESET_N |-> (MODULE_ENABLE[13:4] == 10'h000 && MODULE_ENABLE[26:23] == 4'h0
                      && MODULE_ENABLE[28] == 1'b0 && MODULE_ENABLE[1:0] == 2'h0
                      && MODULE_ENABLE[18:16] == 3'h0 && MODULE_ENABLE[21:20] == 2'h0
                      && MODULE_ENABLE[40:39] == 2'h0);
  endproperty
  a_sync_reset: assert property (p_sync_reset)
    else $error("unlisted module left enabled");

  property p_fixed_en;
    CORE_RESET_N |-> (MODULE_ENABLE[38:29] == 10'h3FF && MODULE_ENABLE[MOD_TIMER0]);
  endproperty
  a_fixed_en: assert property (p_fixed_en)
    else $error("fixed module not enabled");

  property p_strap_mods;
    CORE_RESET_N |->
      (MODULE_ENABLE[MOD_DMA_CC] == (BOOT_CONFIG_REG[1:0] != BOOT_CARD))
      && (MODULE_ENABLE[MOD_DMA_TC0] == (BOOT_CONFIG_REG[1:0] != BOOT_CARD))
      && (MODULE_ENABLE[MOD_ASYNC_MEM] == (BOOT_CONFIG_REG[1:0] != BOOT_CARD))
      && (MODULE_ENABLE[MOD_CARD0] == (BOOT_CONFIG_REG[1:0] == BOOT_CARD))
      && (MODULE_ENABLE[MOD_UART0] == (BOOT_CONFIG_REG[1:0] == BOOT_UART))
      && (MODULE_ENABLE[MOD_SPI0] == (BOOT_CONFIG_REG[1:0] != BOOT_ASYNC));
  endproperty
  a_strap_mods: assert property (p_strap_mods)
    else $error("strap-dependent module state wrong");

  property p_vector;
    FETCH_OVERRIDE |->
      JUMP_TARGET == ((BOOT_CONFIG_REG[1:0] == BOOT_ASYNC) ? ASYNC_VECTOR : ROM_VECTOR);
  endproperty
  a_vector: assert property (p_vector)
    else $error("forced jump target wrong");

  property p_timing_hold;
    (CORE_RESET_N && !(CE && (TIMING_WR_EN || any_rst))) |=> $stable({ASYNC_SETUP, ASYNC_STROBE, ASYNC_HOLD});
  endproperty
  a_timing_hold: assert property (p_timing_hold)
    else $error("async timing changed without a write");

  property p_latch;
    (CE && STRAP_SAMPLING && !any_rst && r_reg.cnt == LAST_CNT) |=>
      (CORE_RESET_N && BOOT_CONFIG_REG == {$past(cfg_pin), $past(sel_pin)} && FETCH_OVERRIDE);
  endproperty
  a_latch: assert property (p_latch)
    else $error("straps not latched at end of sampling");

  property p_strap_stable;
    (CORE_RESET_N && !(CE && any_rst)) |=> $stable(BOOT_CONFIG_REG);
  endproperty
  a_strap_stable: assert property (p_strap_stable)
    else $error("latched straps changed before reset");

  property p_timing_default;
    $rose(CORE_RESET_N) |-> (ASYNC_SETUP == SETUP_RST && ASYNC_STROBE == STROBE_RST
                             && ASYNC_HOLD == HOLD_RST);
  endproperty
  a_timing_default: assert property (p_timing_default)
    else $error("async timing not slowest after reset");

  // Sampling window: everything held at its defaults
  property p_sample_quiet;
    STRAP_SAMPLING |-> (MODULE_ENABLE == 41'h000_0000_0000 && !FETCH_OVERRIDE);
  endproperty
  a_sample_quiet: assert property (p_sample_quiet)
    else $error("module enabled or override set while sampling");

  property p_pll_refused;
    (CE && STRAP_SAMPLING) |=>
      (PLL_BYPASS == PLL_BYPASS_RST && PLL_ENABLE == PLL_ENABLE_RST);
  endproperty
  a_pll_refused: assert property (p_pll_refused)
    else $error("PLL write taken while sampling");

  property p_timing_refused;
    STRAP_SAMPLING |->
      (ASYNC_SETUP == SETUP_RST && ASYNC_STROBE == STROBE_RST && ASYNC_HOLD == HOLD_RST);
  endproperty
  a_timing_refused: assert property (p_timing_refused)
    else $error("async timing left default while sampling");

  property p_sample_straps;
    STRAP_SAMPLING |->
      (BOOT_CONFIG_REG == {CFG_PULL, SEL_PULL} && JUMP_TARGET == ROM_VECTOR);
  endproperty
  a_sample_straps: assert property (p_sample_straps)
    else $error("boot config not at pull values while sampling");

  // Run phase: writes land one edge later, first fetch drops the override, nothing else moves
  property p_pll_write;
    (CE && CORE_RESET_N && PLL_WR_EN && !any_rst) |=>
      (PLL_BYPASS == $past(PLL_WR_BYPASS) && PLL_ENABLE == $past(PLL_WR_ENABLE));
  endproperty
  a_pll_write: assert property (p_pll_write)
    else $error("PLL write did not land");

  property p_pll_hold;
    (CORE_RESET_N && !(CE && (PLL_WR_EN || any_rst))) |=>
      ($stable(PLL_BYPASS) && $stable(PLL_ENABLE));
  endproperty
  a_pll_hold: assert property (p_pll_hold)
    else $error("PLL state changed without a write");

  property p_timing_write;
    (CE && CORE_RESET_N && TIMING_WR_EN && !any_rst) |=>
      (ASYNC_SETUP == $past(TIMING_WR_SETUP) && ASYNC_STROBE == $past(TIMING_WR_STROBE)
       && ASYNC_HOLD == $past(TIMING_WR_HOLD));
  endproperty
  a_timing_write: assert property (p_timing_write)
    else $error("timing write did not land");

  property p_fetch_take;
    (CE && FETCH_OVERRIDE && FIRST_FETCH && !any_rst) |=> !FETCH_OVERRIDE;
  endproperty
  a_fetch_take: assert property (p_fetch_take)
    else $error("override not consumed by first fetch");

  property p_override_stands;
    (FETCH_OVERRIDE && !(CE && (FIRST_FETCH || any_rst))) |=> FETCH_OVERRIDE;
  endproperty
  a_override_stands: assert property (p_override_stands)
    else $error("override dropped before first fetch");

  property p_jump_run;
    CORE_RESET_N |->
      JUMP_TARGET == ((BOOT_CONFIG_REG[1:0] == BOOT_ASYNC) ? ASYNC_VECTOR : ROM_VECTOR);
  endproperty
  a_jump_run: assert property (p_jump_run)
    else $error("jump target does not match boot select");

  property p_config_hold;
    (CORE_RESET_N && !(CE && any_rst)) |=>
      ($stable(MODULE_ENABLE) && $stable(JUMP_TARGET));
  endproperty
  a_config_hold: assert property (p_config_hold)
    else $error("module or jump state changed before reset");

  property p_run_stays;
    (CORE_RESET_N && !(CE && any_rst)) |=> CORE_RESET_N;
  endproperty
  a_run_stays: assert property (p_run_stays)
    else $error("core dropped back into reset without a reset");

  c_boot_async: cover property (CORE_RESET_N && BOOT_CONFIG_REG[1:0] == BOOT_ASYNC);
  c_boot_card:  cover property (CORE_RESET_N && BOOT_CONFIG_REG[1:0] == BOOT_CARD);
  c_boot_uart:  cover property (CORE_RESET_N && BOOT_CONFIG_REG[1:0] == BOOT_UART);
  c_warm_rerun: cover property (CORE_RESET_N ##1 any_rst ##[1:8] $rose(CORE_RESET_N));
  c_slow_fetch: cover property (FETCH_OVERRIDE [*8] ##1 !FETCH_OVERRIDE);

endmodule : rbc_top
